// ==== rtl/carrier_reset_ctrl.sv ====
`timescale 1ns/1ps
module carrier_reset_ctrl #(
    parameter int unsigned SLOTS = carrier_reset_pkg::SLOT_COUNT,
    parameter int unsigned GLITCH_CYCLES = carrier_reset_pkg::GLITCH_CYCLES,
    parameter int unsigned HOLD_CYCLES = carrier_reset_pkg::HOLD_CYCLES,
    parameter int unsigned POWERUP_CYCLES = carrier_reset_pkg::POWERUP_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ext_reset_n,
    input wire logic bus_reset,
    input wire logic soft_reset,
    input wire logic [SLOTS-1:0] slot_reset_request,
    input wire logic jtag_select_write,
    input wire logic jtag_select_value,
    output logic board_reset,
    output logic [SLOTS-1:0] slot_reset,
    output logic link_clear,
    output logic reset_led,
    output logic jtag_select
);
    import carrier_reset_pkg::*;

    logic ext_request;
    logic [HOLD_WIDTH-1:0] hold_reg;
    logic [HOLD_WIDTH-1:0] hold_next;
    logic powerup_done_reg;
    logic powerup_done_next;
    logic board_reset_reg;
    logic board_reset_next;
    logic jtag_sel_reg;
    logic jtag_sel_next;
    logic hold_active;
    logic direct_reset;

    reset_input_filter #(
        .MIN_LOW_CYCLES(GLITCH_CYCLES)
    ) filter_inst (
        .clock(clock),
        .rst(rst),
        .ext_reset_n(ext_reset_n),
        .request(ext_request)
    );

    assign hold_active = hold_reg != HOLD_RESET_VALUE;
    assign direct_reset = bus_reset || soft_reset || (|slot_reset_request);

    always_comb begin
        hold_next = hold_reg;
        powerup_done_next = powerup_done_reg;
        if (!powerup_done_reg) begin
            // rst stands for power-on; the hold counter doubles as power-up timer
            hold_next = HOLD_WIDTH'(POWERUP_CYCLES);
            powerup_done_next = 1'b1;
        end else if (ext_request) begin
            hold_next = HOLD_WIDTH'(HOLD_CYCLES);
        end else if (hold_active) begin
            hold_next = hold_reg - HOLD_WIDTH'(1);
        end
        board_reset_next = hold_active || direct_reset || !powerup_done_reg;
    end

    always_comb begin
        jtag_sel_next = jtag_sel_reg;
        if (board_reset_reg) begin
            jtag_sel_next = JTAG_SEL_HEADER_IN;
        end else if (jtag_select_write) begin
            jtag_sel_next = jtag_select_value;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            hold_reg <= HOLD_RESET_VALUE;
            powerup_done_reg <= 1'b0;
            board_reset_reg <= 1'b1;
        end else begin
            hold_reg <= hold_next;
            powerup_done_reg <= powerup_done_next;
            board_reset_reg <= board_reset_next;
        end
    end

    // selector state; later resets force it back through board_reset_reg
    always_ff @(posedge clock) begin
        if (rst) begin
            jtag_sel_reg <= JTAG_SEL_HEADER_IN;
        end else begin
            jtag_sel_reg <= jtag_sel_next;
        end
    end

    assign board_reset = board_reset_reg;
    assign slot_reset = {SLOTS{board_reset_reg}};
    assign link_clear = board_reset_reg;
    assign reset_led = board_reset_reg;
    assign jtag_select = jtag_sel_reg;

    // the filter pulse loads the counter first, so board reset follows one edge later
    property p_hold_after_request;
        @(posedge clock) disable iff (rst)
        ext_request |=> ##1 board_reset [*8];
    endproperty
    a_hold_after_request: assert property (p_hold_after_request)
        else $error("board reset dropped soon after external request");

    property p_hold_reload;
        @(posedge clock) disable iff (rst)
        ext_request |=> hold_reg == HOLD_WIDTH'(HOLD_CYCLES);
    endproperty
    a_hold_reload: assert property (p_hold_reload)
        else $error("hold not restarted by request");

    property p_direct_reset;
        @(posedge clock) disable iff (rst)
        direct_reset |=> board_reset;
    endproperty
    a_direct_reset: assert property (p_direct_reset)
        else $error("bus, soft or slot reset not passed on");

    property p_release;
        @(posedge clock) disable iff (rst)
        (powerup_done_reg && !hold_active && !direct_reset) |=> !board_reset;
    endproperty
    a_release: assert property (p_release)
        else $error("board reset held with no cause");

    property p_jtag_default;
        @(posedge clock) disable iff (rst)
        board_reset |=> jtag_select == JTAG_SEL_HEADER_IN;
    endproperty
    a_jtag_default: assert property (p_jtag_default)
        else $error("jtag selector not returned to header input");

    property p_jtag_write;
        @(posedge clock) disable iff (rst)
        (!board_reset && jtag_select_write) |=> jtag_select == $past(jtag_select_value);
    endproperty
    a_jtag_write: assert property (p_jtag_write)
        else $error("jtag selector write lost");

    property p_outputs_follow;
        @(posedge clock) disable iff (rst)
        reset_led == board_reset && link_clear == board_reset && slot_reset == {SLOTS{board_reset}};
    endproperty
    a_outputs_follow: assert property (p_outputs_follow)
        else $error("reset outputs disagree");

    property p_powerup;
        @(posedge clock)
        $fell(rst) |-> board_reset ##1 board_reset;
    endproperty
    a_powerup: assert property (p_powerup)
        else $error("no power-up reset");

    property p_powerup_load;
        @(posedge clock) disable iff (rst)
        !powerup_done_reg |=> hold_reg == HOLD_WIDTH'(POWERUP_CYCLES);
    endproperty
    a_powerup_load: assert property (p_powerup_load)
        else $error("power-up length not loaded");

    property p_hold_count;
        @(posedge clock) disable iff (rst)
        (powerup_done_reg && !ext_request && hold_active) |=>
            hold_reg == $past(hold_reg) - HOLD_WIDTH'(1);
    endproperty
    a_hold_count: assert property (p_hold_count)
        else $error("hold counter did not count down");

    property p_hold_keeps;
        @(posedge clock) disable iff (rst)
        hold_active |=> board_reset;
    endproperty
    a_hold_keeps: assert property (p_hold_keeps)
        else $error("board reset released while hold running");

    property p_bus_reset;
        @(posedge clock) disable iff (rst)
        bus_reset |=> board_reset;
    endproperty
    a_bus_reset: assert property (p_bus_reset)
        else $error("bus reset not passed on");

    property p_soft_reset;
        @(posedge clock) disable iff (rst)
        soft_reset |=> board_reset;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("software reset not passed on");

    property p_slot_request;
        @(posedge clock) disable iff (rst)
        (|slot_reset_request) |=> (&slot_reset) && link_clear;
    endproperty
    a_slot_request: assert property (p_slot_request)
        else $error("slot request did not reset every slot");

    // rst in the past term covers a one-edge reset pulse
    property p_led_cause;
        @(posedge clock) disable iff (rst)
        reset_led |-> $past(hold_active || direct_reset || !powerup_done_reg || rst);
    endproperty
    a_led_cause: assert property (p_led_cause)
        else $error("reset indicator lit with no cause");

    property p_jtag_stable;
        @(posedge clock) disable iff (rst)
        (!board_reset && !jtag_select_write) |=> $stable(jtag_select);
    endproperty
    a_jtag_stable: assert property (p_jtag_stable)
        else $error("jtag selector changed without a write");
endmodule

// ==== rtl/carrier_reset_pkg.sv ====
package carrier_reset_pkg;
    localparam int unsigned CLOCK_HZ = 50000000;
    localparam int unsigned CLOCK_PERIOD_NS = 20;
    // shortest low level that counts as a reset request
    localparam int unsigned GLITCH_MIN_NS = 100;
    localparam int unsigned GLITCH_CYCLES = (GLITCH_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // reset hold after a qualified request, in milliseconds
    localparam int unsigned HOLD_MS = 200;
    localparam int unsigned HOLD_CYCLES = HOLD_MS * (CLOCK_HZ / 1000);
    // power-up reset length, chosen equal to the hold
    localparam int unsigned POWERUP_CYCLES = HOLD_CYCLES;
    localparam int unsigned SLOT_COUNT = 4;
    localparam int unsigned HOLD_WIDTH = 24;
    localparam logic [HOLD_WIDTH-1:0] HOLD_RESET_VALUE = 24'h000000;
    localparam logic JTAG_SEL_HEADER_IN = 1'b0;
    localparam logic JTAG_SEL_ONBOARD = 1'b1;
endpackage

// ==== rtl/reset_input_filter.sv ====
`timescale 1ns/1ps
module reset_input_filter #(
    parameter int unsigned MIN_LOW_CYCLES = carrier_reset_pkg::GLITCH_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ext_reset_n,
    output logic request
);
    import carrier_reset_pkg::*;

    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic [7:0] low_count_reg;
    logic [7:0] low_count_next;
    logic request_reg;
    logic request_next;
    logic low_stable;

    // a low counts once stages 2 and 3 agree; stage 1 feeds stage 2 only
    assign low_stable = !sync_reg[1] && !sync_reg[2];

    always_comb begin
        sync_next = {sync_reg[1:0], ext_reset_n};
        low_count_next = low_count_reg;
        request_next = 1'b0;
        if (!low_stable) begin
            low_count_next = 8'h00;
        end else if (low_count_reg < 8'(MIN_LOW_CYCLES)) begin
            low_count_next = low_count_reg + 8'h01;
        end
        // keeps requesting while low, so the hold restarts each cycle
        if (low_stable && low_count_reg + 8'h01 >= 8'(MIN_LOW_CYCLES)) begin
            request_next = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            // idle high, as the pull-up leaves it
            sync_reg <= 3'h7;
            low_count_reg <= 8'h00;
            request_reg <= 1'b0;
        end else begin
            sync_reg <= sync_next;
            low_count_reg <= low_count_next;
            request_reg <= request_next;
        end
    end

    assign request = request_reg;
endmodule

// ==== verif/reset_switch_model.sv ====
`timescale 1ns/1ps
module reset_switch_model (
    input wire logic clock,
    output logic ext_reset_n
);
    // pull-up: a released pin reads high, never floats
    initial ext_reset_n = 1'h1;
    task automatic press(input int cycles);
        @(negedge clock);
        ext_reset_n = 1'h0;
        repeat (cycles) @(negedge clock);
        ext_reset_n = 1'h1;
    endtask
endmodule

// ==== verif/carrier_reset_and_jtag_select_tb_top.sv ====
`timescale 1ns/1ps
module carrier_reset_and_jtag_select_tb_top;
    import carrier_reset_pkg::*;
    localparam int HOLD = 20;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic bus_reset = 1'h0;
    logic soft_reset = 1'h0;
    logic jtag_select_write = 1'h0;
    logic jtag_select_value = 1'h0;
    logic [SLOT_COUNT-1:0] slot_reset_request = '0;
    logic ext_reset_n, board_reset, link_clear, reset_led, jtag_select;
    logic [SLOT_COUNT-1:0] slot_reset;
    logic [7:0] expect_q[$];
    int miscompares = 0;
    int checks = 0;
    int seed = 32'h2eca3cc4;
    int width;
    event snap;
    always #10 clock = ~clock;
    reset_switch_model sw (.clock(clock), .ext_reset_n(ext_reset_n));
    // short hold keeps the run brief; the pulse-width bounds in cmp_range scale with it
    carrier_reset_ctrl #(.HOLD_CYCLES(HOLD), .POWERUP_CYCLES(HOLD)) dut (
        .clock(clock), .rst(rst), .ext_reset_n(ext_reset_n), .bus_reset(bus_reset),
        .soft_reset(soft_reset), .slot_reset_request(slot_reset_request),
        .jtag_select_write(jtag_select_write), .jtag_select_value(jtag_select_value),
        .board_reset(board_reset), .slot_reset(slot_reset), .link_clear(link_clear),
        .reset_led(reset_led), .jtag_select(jtag_select));
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic note(input logic [7:0] exp);
        expect_q.push_back(exp);
        -> snap;
    endtask
    task automatic cmp_snap(input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t outputs %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_range(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("CHECK FAILED %0t reset width %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // width of the next board reset pulse; -1 when none starts within 40 cycles
    task automatic measure(output int n);
        int w;
        w = 0;
        n = -1;
        while (board_reset !== 1'h1 && w < 40) begin
            @(negedge clock);
            w++;
        end
        if (board_reset === 1'h1) begin
            n = 0;
            while (board_reset === 1'h1 && n < 200) begin
                @(negedge clock);
                n++;
            end
        end
    endtask
    task automatic jtag(input logic v);
        jtag_select_write = 1'h1;
        jtag_select_value = v;
        @(negedge clock);
        jtag_select_write = 1'h0;
        @(negedge clock);
        note({7'h0, v});
    endtask
    always @(snap) cmp_snap(expect_q.pop_front(),
        {board_reset, slot_reset, link_clear, reset_led, jtag_select});
    initial begin
        #(20 * 2000);
        miscompares++;
        conclude();
    end
    initial begin
        repeat (3) @(negedge clock);
        rst = 1'h0;
        @(negedge clock);
        note(8'hfe);
        measure(width);
        cmp_range(width, HOLD - 2, HOLD + 6);
        jtag(1'h1);
        // second reset mid-run must put the selector back to header input
        rst = 1'h1;
        repeat (2) @(negedge clock);
        rst = 1'h0;
        @(negedge clock);
        note(8'hfe);
        measure(width);
        cmp_range(width, HOLD - 2, HOLD + 6);
        sw.press(1 + $unsigned($random(seed)) % 3);
        measure(width);
        cmp_range(width, -1, -1);
        sw.press(11);
        note(8'hfe);
        measure(width);
        cmp_range(width, HOLD - 2, HOLD + 6);
        sw.press(11);
        repeat (8) @(negedge clock);
        sw.press(11);
        measure(width);
        cmp_range(width, HOLD - 2, HOLD + 6);
        for (int k = 0; k < SLOT_COUNT + 2; k++) begin
            jtag(1'h1);
            bus_reset = (k == 0);
            soft_reset = (k == 1);
            slot_reset_request = (k > 1) ? SLOT_COUNT'(32'h1 << (k - 2)) : '0;
            repeat (2) @(negedge clock);
            note(8'hfe);
            bus_reset = 1'h0;
            soft_reset = 1'h0;
            slot_reset_request = '0;
            repeat (4) @(negedge clock);
            note(8'h00);
        end
        jtag(1'h1);
        jtag(1'h0);
        conclude();
    end
endmodule
